//--- verilog/ic_codec_pkg.sv
package ic_codec_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TXA  = 8'h04;
  localparam logic [7:0] ADDR_TXB  = 8'h08;
  localparam logic [7:0] ADDR_TXC  = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_RXA  = 8'h14;
  localparam logic [7:0] ADDR_RXB  = 8'h18;
  localparam logic [7:0] ADDR_RXC  = 8'h1c;

  localparam logic [31:0] CTRL_MASK  = 32'h0000007f;
  localparam logic [31:0] TXA_MASK   = 32'h3f073f3f;
  localparam logic [31:0] TXB_MASK   = 32'h3f3f0737;
  localparam logic [31:0] TXC_MASK   = 32'h7fffffff;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] TXA_RESET  = 32'h00070000;
  localparam logic [31:0] TXB_RESET  = 32'h00000707;
  localparam logic [31:0] TXC_RESET  = 32'h0ccccccc;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_PHASE_LSB   = 1;
  localparam int CTRL_BEARER_LSB  = 3;
  localparam int CTRL_LOOPREQ_BIT = 5;
  localparam int CTRL_LOOPACT_BIT = 6;
  localparam int SEQ_LSB          = 0;
  localparam int GROUP_LSB        = 8;
  localparam int MODE_LSB         = 16;
  localparam int RATE_LSB         = 24;
  localparam int FINE_LSB         = 0;
  localparam int BASE_BIT         = 4;
  localparam int MAKER_BIT        = 5;
  localparam int ISSUE_LSB        = 8;
  localparam int EQ_BIT           = 12;
  localparam int REQ_BIT          = 13;
  localparam int ACT_BIT          = 14;
  localparam int SUBADDR_LSB      = 16;
  localparam int XFER_LSB         = 24;
  localparam int COUNT_LSB        = 28;
  localparam int STAT_LOCK_BIT    = 0;
  localparam int STAT_NEW_BIT     = 1;
  localparam int STAT_LOST_BIT    = 2;
  localparam int STAT_GROUP_BIT   = 3;

  // ---------------------------------------------------------------
  // Frame constants
  // ---------------------------------------------------------------
  localparam logic [6:0] ALIGN_BODY    = 7'h3f;
  localparam logic [3:0] FRAME_LAST    = 4'hf;
  localparam logic [3:0] DIGIT_FIRST   = 4'h9;
  localparam logic [7:0] IC_POSITION   = 8'h80;
  localparam logic [3:0] END_OF_NUMBER = 4'hc;
  localparam logic [2:0] FILL_ONES     = 3'h7;
  localparam logic [2:0] FINE_MAX_56   = 3'h6;
  localparam logic [2:0] MODE_0        = 3'h0;
  localparam logic [2:0] MODE_1        = 3'h1;
  localparam logic [2:0] MODE_2        = 3'h2;
  localparam logic [2:0] MODE_3        = 3'h3;

  typedef enum logic [1:0] {
    PHASE_NEGOTIATE = 2'h0,
    PHASE_EQUALIZE  = 2'h1,
    PHASE_CALL      = 2'h2,
    PHASE_IDLE      = 2'h3
  } phase_t;

  typedef enum logic [1:0] {
    BEARER_64      = 2'h0,
    BEARER_56_FAC  = 2'h1,
    BEARER_56_BASE = 2'h2,
    BEARER_SPARE   = 2'h3
  } bearer_t;

  typedef enum logic [2:0] {
    RX_HUNT   = 3'b001,
    RX_VERIFY = 3'b010,
    RX_LOCKED = 3'b100
  } rx_state_t;

endpackage

//--- verilog/control_frame_channel.sv
`timescale 1ns/100ps
// Behaviour
// - Negotiation uses whole master channel bandwidth
// - Modes 2,3: octet 128 equalize through call
// - Mode 1 octet 128 only equalizing; mode 0 none
// - Frame opens with zero-then-ones alignment octet
// - Later octets carry leading one marker
// - 64k bearers send eighth bit one
// - 56k facility: eighth bit is network signalling
// - 56k baseband: seven-bit units only
// - Octet 2 channel number; zero means negotiation
// - First channel is 1, ascending; rx orders
// - Sent channel numbers independent of received
// - Octet 3 carries call group tag
// - Group tag zero only while negotiating
// - Octet 4 carries three-bit operating mode
// - Reserved bits sent one, ignored on receipt
// - Octet 5 carries six-bit rate factor
// - Modes 0-2: fine factor ones, ignored
// - Mode 3 fine factor max 6 or 7
// - Octet 6 bit 5 selects base rate
// - Octet 6 bit 7 flags maker code
// - Octet 7 bit 2 marks equalized call
// - Octet 7 bit 3 requests far loopback
// - Octet 7 bit 4 reports own loopback
// - Octet 7 bits 5-7 issue level, ones unused
// - Digits left justified, end code fills rest
module control_frame_channel
  import ic_codec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [3:0]  sel,
  input  wire logic [7:0]  adr,
  input  wire logic [31:0] dat_w,
  output logic      [31:0] dat_r,
  output logic             ack,
  input  wire logic        bearer_tick,
  input  wire logic [7:0]  agg_octet_pos,
  input  wire logic        sig_off_hook,
  output logic      [7:0]  tx_octet,
  output logic             tx_octet_valid,
  output logic             tx_frame_start,
  output logic             tx_seven_bit,
  input  wire logic [7:0]  rx_octet,
  input  wire logic        rx_octet_valid,
  output logic             rx_locked
);

  // ---------------------------------------------------------------
  // Registers and bus slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl, txa, txb, txc, rxa, rxb, rxc;
  logic [31:0] next_ctrl, next_txa, next_txb, next_txc;
  logic [31:0] next_dat_r;
  logic        next_ack;
  logic        st_new, st_lost, st_group;
  logic        next_st_new, next_st_lost, next_st_group;
  logic        access, wr_stat, rx_commit, rx_break, group_misuse;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat_w[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  assign access  = cyc & stb & ~ack;
  assign wr_stat = access & we & (adr == ADDR_STAT) & sel[0];

  always_comb begin
    next_ack      = access;
    next_dat_r    = dat_r;
    next_ctrl     = ctrl;
    next_txa      = txa;
    next_txb      = txb;
    next_txc      = txc;
    if (access && we) begin
      case (adr)
        ADDR_CTRL: next_ctrl = merge(ctrl, CTRL_MASK);
        ADDR_TXA:  next_txa  = merge(txa, TXA_MASK);
        ADDR_TXB:  next_txb  = merge(txb, TXB_MASK);
        ADDR_TXC:  next_txc  = merge(txc, TXC_MASK);
        default:   next_ctrl = ctrl;
      endcase
    end
    if (access && !we) begin
      case (adr)
        ADDR_CTRL: next_dat_r = ctrl;
        ADDR_TXA:  next_dat_r = txa;
        ADDR_TXB:  next_dat_r = txb;
        ADDR_TXC:  next_dat_r = txc;
        ADDR_STAT: next_dat_r = {28'h0, st_group, st_lost, st_new, rx_locked};
        ADDR_RXA:  next_dat_r = rxa;
        ADDR_RXB:  next_dat_r = rxb;
        ADDR_RXC:  next_dat_r = rxc;
        default:   next_dat_r = 32'h0;
      endcase
    end
    // Hardware set wins over a write-one clear in the same cycle
    next_st_new   = (st_new & ~(wr_stat & dat_w[STAT_NEW_BIT])) | rx_commit;
    next_st_lost  = (st_lost & ~(wr_stat & dat_w[STAT_LOST_BIT])) | rx_break;
    next_st_group = (st_group & ~(wr_stat & dat_w[STAT_GROUP_BIT])) | group_misuse;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack      <= 1'b0;
      dat_r    <= 32'h0;
      ctrl     <= CTRL_RESET;
      txa      <= TXA_RESET;
      txb      <= TXB_RESET;
      txc      <= TXC_RESET;
      st_new   <= 1'b0;
      st_lost  <= 1'b0;
      st_group <= 1'b0;
    end else begin
      ack      <= next_ack;
      dat_r    <= next_dat_r;
      ctrl     <= next_ctrl;
      txa      <= next_txa;
      txb      <= next_txb;
      txc      <= next_txc;
      st_new   <= next_st_new;
      st_lost  <= next_st_lost;
      st_group <= next_st_group;
    end
  end

  // ---------------------------------------------------------------
  // Transmit framer
  // ---------------------------------------------------------------
  phase_t     phase;
  bearer_t    bearer;
  logic [2:0] mode, fine;
  logic       tx_en, ic_here, bit8;
  logic [3:0] tx_idx, next_tx_idx, out_idx, next_out_idx;
  logic [7:0] next_tx_octet;
  logic       next_tx_valid, next_tx_start, next_tx_seven;

  assign phase  = phase_t'(ctrl[CTRL_PHASE_LSB +: 2]);
  assign bearer = bearer_t'(ctrl[CTRL_BEARER_LSB +: 2]);
  assign tx_en  = ctrl[CTRL_EN_BIT];
  assign mode   = txa[MODE_LSB +: 3];

  always_comb begin
    case (phase)
      PHASE_NEGOTIATE: ic_here = 1'b1;
      PHASE_EQUALIZE:  ic_here = (mode == MODE_1 || mode == MODE_2 || mode == MODE_3)
                                 && agg_octet_pos == IC_POSITION;
      PHASE_CALL:      ic_here = (mode == MODE_2 || mode == MODE_3)
                                 && agg_octet_pos == IC_POSITION;
      default:         ic_here = 1'b0;
    endcase
    ic_here = ic_here & tx_en & bearer_tick;
  end

  always_comb begin
    fine = txb[FINE_LSB +: 3];
    if (mode != MODE_3) begin
      fine = FILL_ONES;
    end else if (!txb[BASE_BIT] && fine > FINE_MAX_56) begin
      fine = FINE_MAX_56;
    end
    case (bearer)
      BEARER_56_FAC:  bit8 = sig_off_hook;
      BEARER_56_BASE: bit8 = 1'b0;
      default:        bit8 = 1'b1;
    endcase
  end

  // Seven-bit body b1..b7 of the octet at a given frame index
  function automatic logic [6:0] tx_body(input logic [3:0] idx);
    logic [2:0] k;
    logic [3:0] dig;
    k   = 3'(idx - DIGIT_FIRST);
    dig = (k < txc[COUNT_LSB +: 3]) ? txc[4*k +: 4] : END_OF_NUMBER;
    case (idx)
      4'h0: tx_body = ALIGN_BODY;
      4'h1: tx_body = {1'b1, txa[SEQ_LSB +: 6]};
      4'h2: tx_body = {1'b1, txa[GROUP_LSB +: 6]};
      4'h3: tx_body = {1'b1, mode, FILL_ONES};
      4'h4: tx_body = {1'b1, txa[RATE_LSB +: 6]};
      4'h5: tx_body = {1'b1, fine, txb[BASE_BIT], 1'b1, txb[MAKER_BIT]};
      4'h6: tx_body = {1'b1, phase == PHASE_CALL, ctrl[CTRL_LOOPREQ_BIT],
                       ctrl[CTRL_LOOPACT_BIT], txb[ISSUE_LSB +: 3]};
      4'h7: tx_body = {1'b1, txb[SUBADDR_LSB +: 6]};
      4'h8: tx_body = {1'b1, txb[XFER_LSB +: 6]};
      default: tx_body = {3'b111, dig};
    endcase
  endfunction

  always_comb begin
    next_tx_idx   = tx_idx;
    next_out_idx  = out_idx;
    next_tx_octet = tx_octet;
    next_tx_valid = 1'b0;
    next_tx_start = 1'b0;
    next_tx_seven = (bearer == BEARER_56_BASE);
    group_misuse  = 1'b0;
    if (ic_here) begin
      next_tx_octet = {tx_body(tx_idx), bit8};
      next_tx_valid = 1'b1;
      next_tx_start = (tx_idx == 4'h0);
      next_out_idx  = tx_idx;
      next_tx_idx   = tx_idx + 4'h1;
      group_misuse  = (tx_idx == 4'h2) && phase != PHASE_NEGOTIATE
                      && txa[GROUP_LSB +: 6] == 6'h0;
    end
    if (!tx_en) begin
      next_tx_idx = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_idx         <= 4'h0;
      out_idx        <= 4'h0;
      tx_octet       <= 8'h0;
      tx_octet_valid <= 1'b0;
      tx_frame_start <= 1'b0;
      tx_seven_bit   <= 1'b0;
    end else begin
      tx_idx         <= next_tx_idx;
      out_idx        <= next_out_idx;
      tx_octet       <= next_tx_octet;
      tx_octet_valid <= next_tx_valid;
      tx_frame_start <= next_tx_start;
      tx_seven_bit   <= next_tx_seven;
    end
  end

  // ---------------------------------------------------------------
  // Receive deframer
  // ---------------------------------------------------------------
  rx_state_t  rx_state, next_rx_state;
  logic [3:0] rx_idx, next_rx_idx;
  logic [6:0] rx_buf [15];
  logic [6:0] next_rx_buf [15];
  logic [6:0] body;
  logic [31:0] next_rxa, next_rxb, next_rxc;
  logic       is_align, next_rx_locked;

  assign body     = rx_octet[7:1];
  assign is_align = (body == ALIGN_BODY);

  always_comb begin
    next_rx_state = rx_state;
    next_rx_idx   = rx_idx;
    next_rx_buf   = rx_buf;
    next_rxa      = rxa;
    next_rxb      = rxb;
    next_rxc      = rxc;
    rx_commit     = 1'b0;
    rx_break      = 1'b0;
    if (rx_octet_valid) begin
      case (rx_state)
        RX_HUNT: begin
          if (is_align) begin
            next_rx_state = RX_VERIFY;
            next_rx_idx   = 4'h1;
          end
        end
        RX_VERIFY, RX_LOCKED: begin
          if (rx_idx == 4'h0) begin
            if (is_align) begin
              next_rx_idx = 4'h1;
            end else begin
              next_rx_state = RX_HUNT;
              rx_break      = (rx_state == RX_LOCKED);
            end
          end else if (!body[6]) begin
            next_rx_state = is_align ? RX_VERIFY : RX_HUNT;
            next_rx_idx   = 4'h1;
            rx_break      = (rx_state == RX_LOCKED);
          end else begin
            next_rx_buf[4'(rx_idx - 4'h1)] = body;
            next_rx_idx = rx_idx + 4'h1;
            if (rx_idx == FRAME_LAST) begin
              next_rx_state = RX_LOCKED;
              rx_commit     = 1'b1;
              // Reserved fields are dropped; fine factor kept only in mode 3
              next_rxa = {2'h0, next_rx_buf[3][5:0], 5'h0, next_rx_buf[2][5:3],
                          2'h0, next_rx_buf[1][5:0], 2'h0, next_rx_buf[0][5:0]};
              // Equalized flag lands in bit 12, loop active in bit 14
              next_rxb = {2'h0, next_rx_buf[7][5:0], 2'h0, next_rx_buf[6][5:0],
                          1'b0, next_rx_buf[5][3], next_rx_buf[5][4], next_rx_buf[5][5],
                          1'b0, next_rx_buf[5][2:0],
                          2'h0, next_rx_buf[4][0], next_rx_buf[4][2],
                          1'b0, (next_rx_buf[2][5:3] == MODE_3)
                                ? next_rx_buf[4][5:3] : 3'h0};
              next_rxc = {4'h0, next_rx_buf[14][3:0], next_rx_buf[13][3:0],
                          next_rx_buf[12][3:0], next_rx_buf[11][3:0],
                          next_rx_buf[10][3:0], next_rx_buf[9][3:0],
                          next_rx_buf[8][3:0]};
            end
          end
        end
        default: next_rx_state = RX_HUNT;
      endcase
    end
    next_rx_locked = (next_rx_state == RX_LOCKED);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state  <= RX_HUNT;
      rx_idx    <= 4'h0;
      rx_locked <= 1'b0;
      rxa       <= 32'h0;
      rxb       <= 32'h0;
      rxc       <= 32'h0;
      for (int i = 0; i < 15; i++) begin
        rx_buf[i] <= 7'h0;
      end
    end else begin
      rx_state  <= next_rx_state;
      rx_idx    <= next_rx_idx;
      rx_locked <= next_rx_locked;
      rxa       <= next_rxa;
      rxb       <= next_rxb;
      rxc       <= next_rxc;
      rx_buf    <= next_rx_buf;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Index of the last octet sent; parked at the frame end while disabled
  logic [3:0] sent_idx, next_sent_idx;

  always_comb begin
    next_sent_idx = sent_idx;
    if (!tx_en) begin
      next_sent_idx = FRAME_LAST;
    end else if (tx_octet_valid) begin
      next_sent_idx = out_idx;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sent_idx <= FRAME_LAST;
    end else begin
      sent_idx <= next_sent_idx;
    end
  end

  align_octet_a: assert property (tx_octet_valid && tx_frame_start |->
      tx_octet[7:1] == ALIGN_BODY) else $error("alignment octet wrong");
  marker_bit_a: assert property (tx_octet_valid && !tx_frame_start |-> tx_octet[7])
      else $error("marker bit missing");
  frame_order_a: assert property (tx_octet_valid |-> out_idx == 4'(sent_idx + 4'h1)
      && tx_frame_start == (out_idx == 4'h0)) else $error("frame octets out of order");
  bit8_rate_a: assert property (tx_octet_valid && $past(bearer) == BEARER_64
      |-> tx_octet[0]) else $error("eighth bit not one");
  bit8_signal_a: assert property (tx_octet_valid && $past(bearer) == BEARER_56_FAC
      |-> tx_octet[0] == $past(sig_off_hook)) else $error("signalling bit wrong");
  slot_place_a: assert property (tx_octet_valid && $past(phase) != PHASE_NEGOTIATE
      |-> $past(agg_octet_pos) == IC_POSITION) else $error("control octet off slot");
  mode_quiet_a: assert property ($past(phase) != PHASE_NEGOTIATE && $past(mode) == MODE_0
      |-> !tx_octet_valid) else $error("mode 0 sent control octet");
  fine_fill_a: assert property (tx_octet_valid && out_idx == 4'h5 && $past(mode) != MODE_3
      |-> tx_octet[6:4] == FILL_ONES) else $error("fine factor not ones");
  lock_entry_a: assert property ($rose(rx_locked) |-> $past(rx_octet_valid)
      && $past(rx_idx) == FRAME_LAST) else $error("lock without full frame");
  lock_loss_a: assert property (rx_locked && rx_octet_valid && rx_idx != 4'h0
      && !rx_octet[7] |=> !rx_locked && st_lost) else $error("broken frame kept lock");
  bus_ack_a: assert property (cyc && stb && !ack |=> ack ##1 !ack)
      else $error("bus answer not single cycle");

  tx_frame_c: cover property (tx_octet_valid && out_idx == FRAME_LAST);
  rx_lock_c: cover property ($rose(rx_locked));
  rx_loss_c: cover property (rx_break);
  slot_call_c: cover property (tx_octet_valid && phase == PHASE_CALL);

endmodule

//--- verif/far_end_model.sv
`timescale 1ns/100ps
module far_end_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  output logic            bearer_tick,
  output logic      [7:0] agg_octet_pos,
  output logic      [7:0] rx_octet,
  output logic            rx_octet_valid
);
  // ----------------------------------------------------------------
  // Bearer octet clock: one tick a cycle, position wraps every 256
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bearer_tick   <= 1'b0;
      agg_octet_pos <= 8'h00;
    end else begin
      bearer_tick   <= 1'b1;
      agg_octet_pos <= agg_octet_pos + 8'h01;
    end
  end

  initial begin
    rx_octet       = 8'h00;
    rx_octet_valid = 1'b0;
  end

  // ----------------------------------------------------------------
  // Control frame sender, optionally with one broken marker bit
  // ----------------------------------------------------------------
  task automatic send_frame(input logic [5:0] seq, input logic [5:0] grp, input int bad);
    logic [6:0] body;
    for (int k = 1; k <= 16; k++) begin
      case (k)
        1:       body = 7'h3f;
        2:       body = {1'b1, seq};
        3:       body = {1'b1, grp};
        4:       body = 7'h50;
        7:       body = 7'h48;
        default: body = 7'h7f;
      endcase
      if (k == bad)
        body[6] = 1'b0;
      @(posedge clk);
      rx_octet       <= {body, 1'b1};
      rx_octet_valid <= 1'b1;
    end
    @(posedge clk);
    rx_octet       <= ~rx_octet;
    rx_octet_valid <= 1'b0;
  endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench
  import ic_codec_pkg::*;
;
  logic        clk;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic        ack;
  logic        bearer_tick;
  logic [7:0]  agg_octet_pos;
  logic        sig_off_hook;
  logic [7:0]  tx_octet;
  logic        tx_octet_valid;
  logic        tx_frame_start;
  logic        tx_seven_bit;
  logic [7:0]  rx_octet;
  logic        rx_octet_valid;
  logic        rx_locked;
  logic [17:0] q[$];
  logic [7:0]  ppos;
  int          miscompares;
  int          n_checks;

  control_frame_channel DUT (
    .clk(clk), .reset_n(reset_n), .cyc(cyc), .stb(stb), .we(we), .sel(sel), .adr(adr),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .bearer_tick(bearer_tick),
    .agg_octet_pos(agg_octet_pos), .sig_off_hook(sig_off_hook), .tx_octet(tx_octet),
    .tx_octet_valid(tx_octet_valid), .tx_frame_start(tx_frame_start),
    .tx_seven_bit(tx_seven_bit), .rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid),
    .rx_locked(rx_locked));

  far_end_model far (
    .clk(clk), .reset_n(reset_n), .bearer_tick(bearer_tick),
    .agg_octet_pos(agg_octet_pos), .rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Record each sent octet with the slot position of its tick
  always @(posedge clk) begin
    if (tx_octet_valid === 1'b1)
      q.push_back({tx_seven_bit, tx_frame_start, ppos, tx_octet});
    ppos = agg_octet_pos;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                    output logic [31:0] d);
    int n;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= v;
    sel   <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    d = dat_r;
    if (n >= 50)
      chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    wb(1'b1, a, v, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask

  function automatic logic [7:0] exp_oct(input int k, input logic [31:0] a, b, c,
                                         input logic [2:0] fl, input logic b8);
    logic [6:0] y;
    logic [2:0] f;
    f = (a[18:16] != MODE_3) ? FILL_ONES : (!b[4] && b[2:0] == 3'h7) ? FINE_MAX_56 : b[2:0];
    case (k)
      1:       y = ALIGN_BODY;
      2:       y = {1'b1, a[5:0]};
      3:       y = {1'b1, a[13:8]};
      4:       y = {1'b1, a[18:16], FILL_ONES};
      5:       y = {1'b1, a[29:24]};
      6:       y = {1'b1, f, b[4], 1'b1, b[5]};
      7:       y = {1'b1, fl, b[10:8]};
      8:       y = {1'b1, b[21:16]};
      9:       y = {1'b1, b[29:24]};
      default: y = {3'h7, (k - 10 < c[30:28]) ? c[4*(k-10) +: 4] : END_OF_NUMBER};
    endcase
    return {y, b8};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_TXA, TXA_RESET);
    rd(ADDR_TXB, TXB_RESET);
    rd(ADDR_TXC, TXC_RESET);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'h0);
  endtask

  task automatic t_frame(input logic [6:0] ctl, input logic [31:0] a, b, c,
                         input logic [2:0] fl, input logic b8);
    int   n;
    logic call;
    call = (ctl[2:1] != 2'h0);
    wr(ADDR_TXA, a);
    wr(ADDR_TXB, b);
    wr(ADDR_TXC, c);
    q.delete();
    wr(ADDR_CTRL, {25'h0, ctl});
    n = 0;
    while (q.size() < 16 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    wr(ADDR_CTRL, 32'h0);
    chk(32'(q.size() >= 16), 32'h1);
    for (int k = 1; k <= 16 && k <= q.size(); k++)
      chk({14'h0, q[k-1]}, {14'h0, ctl[4:3] == BEARER_56_BASE, k == 1,
          call ? IC_POSITION : q[k-1][15:8], exp_oct(k, a, b, c, fl, b8)});
  endtask

  task automatic t_silent(input logic [6:0] ctl, input logic [31:0] a);
    wr(ADDR_TXA, a);
    q.delete();
    wr(ADDR_CTRL, {25'h0, ctl});
    repeat (600) @(posedge clk);
    wr(ADDR_CTRL, 32'h0);
    chk(32'(q.size()), 32'h0);
  endtask

  task automatic t_group;
    wr(ADDR_TXA, 32'h01020001);
    wr(ADDR_CTRL, 32'h05);
    repeat (1100) @(posedge clk);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_STAT, 32'h8);
    wr(ADDR_STAT, 32'h8);
    rd(ADDR_STAT, 32'h0);
  endtask

  task automatic t_rx;
    far.send_frame(6'h05, 6'h09, 0);
    @(negedge clk);
    chk({31'h0, rx_locked}, 32'h1);
    rd(ADDR_RXA, 32'h3f020905);
    rd(ADDR_RXB, 32'h3f3f4030);
    rd(ADDR_RXC, 32'h0fffffff);
    rd(ADDR_STAT, 32'h3);
    far.send_frame(6'h05, 6'h09, 8);
    @(negedge clk);
    chk({31'h0, rx_locked}, 32'h0);
    rd(ADDR_STAT, 32'h6);
    wr(ADDR_STAT, 32'h6);
    rd(ADDR_STAT, 32'h0);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    cyc          = 1'b0;
    stb          = 1'b0;
    we           = 1'b0;
    sel          = 4'h0;
    adr          = 8'h00;
    dat_w        = 32'h0;
    sig_off_hook = 1'b0;
    reset_n      = 1'b0;
    miscompares  = 0;
    n_checks     = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_frame(7'h01, 32'h3f070000, 32'h152a0733, 32'h35555321, 3'h0, 1'b1);
    t_frame(7'h09, 32'h3f070000, 32'h152a0733, 32'h35555321, 3'h0, 1'b0);
    sig_off_hook <= 1'b1;
    t_frame(7'h09, 32'h3f070000, 32'h152a0733, 32'h35555321, 3'h0, 1'b1);
    sig_off_hook <= 1'b0;
    t_frame(7'h11, 32'h3f070000, 32'h152a0733, 32'h35555321, 3'h0, 1'b0);
    t_frame(7'h1b, 32'h05010701, 32'h00000710, 32'h0ccccccc, 3'h0, 1'b1);
    t_frame(7'h65, 32'h02030702, 32'h00000007, 32'h76543210, 3'h7, 1'b1);
    t_silent(7'h05, 32'h05000701);
    t_silent(7'h05, 32'h05010701);
    t_silent(7'h07, 32'h05020701);
    t_group();
    t_rx();
    report_and_stop();
  end
endmodule
